// ==== rtl/stop_mode_power_controller.sv ====
// Operating-mode controller: STOP entry, wake release, warm-up, TIMEBASE_ONLY_IDLE_MODE.
// Assumes one 40 MHz clock, asynchronous pins and a one-cycle register port.
//
// How it works
// - Writing one to the stop bit of control one enters STOP.
// - STOP halts both oscillators and all internal operation.
// - STOP keeps state; port drive follows the output hold select bit.
// - Entering STOP clears prescaler and divider of the timing generator.
// - During STOP the resume address is stop instruction address plus two.
// - Any system reset ends STOP, then warm-up, then single-clock run mode.
// - Wake pin, key wakeup and voltage detector also release STOP.
// - Release select one: high level on wake pin releases STOP.
// - Level mode refuses STOP while the wake pin is high.
// - Once warm-up starts, wake pin going low does not re-enter STOP.
// - Release select zero: rising edge on wake pin releases STOP.
// - Edge mode enters STOP even with the wake pin already high.
// - A wake edge within one machine cycle of entry is ignored.
// - Warm-up clock is the one that drove the core at entry.
// - TIMEBASE_ONLY_IDLE_MODE ends on a falling edge of the timebase source.
// - Machine cycle: one gear clock normally, four low clocks in slow.
// - After wake release, resume the previous mode at the next instruction.
// - Timing generator halt bit in single-clock run mode enters TIMEBASE_ONLY_IDLE_MODE.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module stop_mode_power_controller (
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire stop_ctrl_pkg::pins_t pins,
	input  wire logic [15:0]          stop_insn_addr,
	input  wire logic [2:0]           addr,
	input  wire logic [7:0]           wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output      logic [7:0]           rdata,
	output      logic                 hf_osc_en,
	output      logic                 lf_osc_en,
	output      logic                 cpu_stall,
	output      logic                 periph_clk_en,
	output      logic                 tbt_clk_en,
	output      logic                 port_drive_en,
	output      logic                 mc_tick,
	output      logic [15:0]          resume_addr,
	output      logic [7:0]           tg_div
);
	stop_ctrl_pkg::pins_t s;
	stop_ctrl_pkg::mode_t state_ff, nxt_state;
	logic [7:0]  sc1_ff, nxt_sc1;
	logic [7:0]  sc2_ff, nxt_sc2;
	logic [7:0]  wucc_ff, nxt_wucc;
	logic [7:0]  wucd_ff, nxt_wucd;
	logic [2:0]  tbtc_ff, nxt_tbtc;
	logic [7:0]  div_ff, nxt_div;
	logic [15:0] pc_ff, nxt_pc;
	logic [7:0]  rdata_ff, nxt_rdata;
	logic        wake_prev_ff, nxt_wake_prev;
	logic        lf_prev_ff, nxt_lf_prev;
	logic        tb_prev_ff, nxt_tb_prev;
	logic [1:0]  lf_cnt_ff, nxt_lf_cnt;
	logic [1:0]  guard_cnt_ff, nxt_guard_cnt;
	logic        guard_ff, nxt_guard;
	logic        warm_lf_ff, nxt_warm_lf;
	logic        wu_start, wu_tick, wu_busy, wu_done;
	logic        wake_rise, lf_rise, tb_src, tb_fall, slow, release_req;

	// ==========================================================
	// Pin synchroniser and warm-up counter
	pin_sync u_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.pins   (pins),
		.pins_s (s)
	);

	warmup_timer u_warm (
		.clock  (clock),
		.arst_n (arst_n),
		.start  (wu_start),
		.tick   (wu_tick),
		.units  (wucd_ff),
		.busy   (wu_busy),
		.done   (wu_done)
	);

	// ==========================================================
	// Edge detection and machine cycle
	always_comb begin
		slow      = sc2_ff[stop_ctrl_pkg::SC2_SLOW];
		wake_rise = s.wake & ~wake_prev_ff;
		lf_rise   = s.lf_clk & ~lf_prev_ff;
		// Slow modes take the low clock level, else a divider tap
		tb_src    = slow ? s.lf_clk : div_ff[tbtc_ff];
		tb_fall   = tb_prev_ff & ~tb_src;
		// Gear mode ticks every clock in run only; slow mode every fourth low edge
		mc_tick   = slow ? (lf_rise && lf_cnt_ff == stop_ctrl_pkg::LF_PER_MC)
		                 : (state_ff == stop_ctrl_pkg::st_run);
		// Warm-up source is frozen at entry, not the programmed select
		wu_tick   = warm_lf_ff ? lf_rise : 1'b1;
		release_req = s.key | s.vd_rel |
			(sc1_ff[stop_ctrl_pkg::SC1_RELEASE_MODE_SELECT] ? s.wake
			                                 : (wake_rise & ~guard_ff));
	end

	// ==========================================================
	// Mode sequencer and register writes
	always_comb begin
		nxt_state     = state_ff;
		nxt_sc1       = sc1_ff;
		nxt_sc2       = sc2_ff;
		nxt_wucc      = wucc_ff;
		nxt_wucd      = wucd_ff;
		nxt_tbtc      = tbtc_ff;
		nxt_pc        = pc_ff;
		nxt_guard     = guard_ff;
		nxt_guard_cnt = guard_cnt_ff;
		nxt_warm_lf   = warm_lf_ff;
		nxt_wake_prev = s.wake;
		nxt_lf_prev   = s.lf_clk;
		nxt_tb_prev   = tb_src;
		nxt_lf_cnt    = lf_rise ? lf_cnt_ff + 2'h1 : lf_cnt_ff;
		// Prescaler runs only in gear mode, during run and timebase-only idle
		nxt_div       = (!slow && (state_ff == stop_ctrl_pkg::st_run ||
		                 state_ff == stop_ctrl_pkg::st_timebase_only_idle_mode)) ? div_ff + 8'h01 : div_ff;
		wu_start      = 1'b0;
		case (state_ff)
			stop_ctrl_pkg::st_reset: begin
				nxt_state   = stop_ctrl_pkg::st_warm;
				nxt_warm_lf = 1'b0;
				wu_start    = 1'b1;
			end
			stop_ctrl_pkg::st_run: begin
				if (wr) begin
					if (addr == stop_ctrl_pkg::ADDR_SC1) begin
						nxt_sc1 = wdata;
						if (wdata[stop_ctrl_pkg::SC1_STOP]) begin
							if (wdata[stop_ctrl_pkg::SC1_RELEASE_MODE_SELECT] && s.wake) begin
								nxt_sc1[stop_ctrl_pkg::SC1_STOP] = 1'b0;
							end else begin
								// Edge mode goes in regardless of the pin
								nxt_state     = stop_ctrl_pkg::st_stop;
								nxt_div       = 8'h00;
								nxt_pc        = stop_insn_addr + stop_ctrl_pkg::PC_STEP;
								nxt_guard     = 1'b1;
								nxt_guard_cnt = 2'h0;
								nxt_warm_lf   = slow;
							end
						end
					end else if (addr == stop_ctrl_pkg::ADDR_SC2) begin
						nxt_sc2 = wdata;
						if (wdata[stop_ctrl_pkg::SC2_TGH]) begin
							nxt_state = stop_ctrl_pkg::st_timebase_only_idle_mode;
						end
					end else if (addr == stop_ctrl_pkg::ADDR_WUCC) begin
						nxt_wucc = wdata;
					end else if (addr == stop_ctrl_pkg::ADDR_WUCD) begin
						nxt_wucd = wdata;
					end else if (addr == stop_ctrl_pkg::ADDR_TBTC) begin
						nxt_tbtc = wdata[2:0];
					end
				end
			end
			stop_ctrl_pkg::st_timebase_only_idle_mode: begin
				if (tb_fall) begin
					nxt_state                      = stop_ctrl_pkg::st_run;
					nxt_sc2[stop_ctrl_pkg::SC2_TGH] = 1'b0;
				end
			end
			stop_ctrl_pkg::st_stop: begin
				// Edge blanking lasts one machine cycle after entry
				if (!warm_lf_ff) begin
					nxt_guard = 1'b0;
				end else if (lf_rise) begin
					nxt_guard_cnt = guard_cnt_ff + 2'h1;
					if (guard_cnt_ff == stop_ctrl_pkg::LF_PER_MC) begin
						nxt_guard = 1'b0;
					end
				end
				if (release_req) begin
					nxt_state = stop_ctrl_pkg::st_warm;
					wu_start  = 1'b1;
				end
			end
			stop_ctrl_pkg::st_warm: begin
				// The wake pin is not looked at here, so it cannot re-stop
				if (wu_done) begin
					nxt_state                        = stop_ctrl_pkg::st_run;
					nxt_sc1[stop_ctrl_pkg::SC1_STOP] = 1'b0;
					nxt_div                          = 8'h00;
				end
			end
			default: nxt_state = stop_ctrl_pkg::st_reset;
		endcase
		// System reset overrides state, SC1, SC2, divider and warm-up start, and lands in single-clock run
		if (s.rst_req) begin
			nxt_state = stop_ctrl_pkg::st_reset;
			nxt_sc1   = stop_ctrl_pkg::SC1_RST;
			nxt_sc2   = stop_ctrl_pkg::SC2_RST;
			nxt_div   = 8'h00;
			wu_start  = 1'b0;
		end
	end

	// ==========================================================
	// Read port: data stand in the cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd) begin
			if (addr == stop_ctrl_pkg::ADDR_SC1) begin
				nxt_rdata = sc1_ff;
			end else if (addr == stop_ctrl_pkg::ADDR_SC2) begin
				nxt_rdata = sc2_ff;
			end else if (addr == stop_ctrl_pkg::ADDR_WUCC) begin
				nxt_rdata = wucc_ff;
			end else if (addr == stop_ctrl_pkg::ADDR_WUCD) begin
				nxt_rdata = wucd_ff;
			end else if (addr == stop_ctrl_pkg::ADDR_TBTC) begin
				nxt_rdata = {5'h00, tbtc_ff};
			end else if (addr == stop_ctrl_pkg::ADDR_STATUS) begin
				nxt_rdata = {3'h0, wu_busy, slow, state_ff};
			end
		end
	end

	// ==========================================================
	// State registers; STOP leaves the register file untouched
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= stop_ctrl_pkg::st_reset;
			sc1_ff       <= stop_ctrl_pkg::SC1_RST;
			sc2_ff       <= stop_ctrl_pkg::SC2_RST;
			wucc_ff      <= stop_ctrl_pkg::WUCC_RST;
			wucd_ff      <= stop_ctrl_pkg::WUCD_RST;
			tbtc_ff      <= stop_ctrl_pkg::TBTC_RST;
			div_ff       <= 8'h00;
			pc_ff        <= 16'h0000;
			rdata_ff     <= 8'h00;
			wake_prev_ff <= 1'b0;
			lf_prev_ff   <= 1'b0;
			tb_prev_ff   <= 1'b0;
			lf_cnt_ff    <= 2'h0;
			guard_cnt_ff <= 2'h0;
			guard_ff     <= 1'b0;
			warm_lf_ff   <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			sc1_ff       <= nxt_sc1;
			sc2_ff       <= nxt_sc2;
			wucc_ff      <= nxt_wucc;
			wucd_ff      <= nxt_wucd;
			tbtc_ff      <= nxt_tbtc;
			div_ff       <= nxt_div;
			pc_ff        <= nxt_pc;
			rdata_ff     <= nxt_rdata;
			wake_prev_ff <= nxt_wake_prev;
			lf_prev_ff   <= nxt_lf_prev;
			tb_prev_ff   <= nxt_tb_prev;
			lf_cnt_ff    <= nxt_lf_cnt;
			guard_cnt_ff <= nxt_guard_cnt;
			guard_ff     <= nxt_guard;
			warm_lf_ff   <= nxt_warm_lf;
		end
	end

	// ==========================================================
	// Outputs
	assign hf_osc_en     = (state_ff != stop_ctrl_pkg::st_stop) &&
	                       sc2_ff[stop_ctrl_pkg::SC2_HFEN];
	assign lf_osc_en     = (state_ff != stop_ctrl_pkg::st_stop) &&
	                       sc2_ff[stop_ctrl_pkg::SC2_LFEN];
	assign cpu_stall     = (state_ff != stop_ctrl_pkg::st_run);
	assign periph_clk_en = (state_ff == stop_ctrl_pkg::st_run);
	assign tbt_clk_en    = periph_clk_en || (state_ff == stop_ctrl_pkg::st_timebase_only_idle_mode);
	assign port_drive_en = (state_ff != stop_ctrl_pkg::st_stop) ||
	                       sc1_ff[stop_ctrl_pkg::SC1_HOLD];
	assign resume_addr   = pc_ff;
	assign tg_div        = div_ff;
	assign rdata         = rdata_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	AST_LEVEL_REFUSE: assert property (
		(state_ff == stop_ctrl_pkg::st_run && !s.rst_req && wr && addr == 3'h0 &&
		 wdata[7] && wdata[6] && s.wake) |=> state_ff == stop_ctrl_pkg::st_run)
		else $error("stop entered with wake pin high in level mode");
	AST_EDGE_ENTER: assert property (
		(state_ff == stop_ctrl_pkg::st_run && !s.rst_req && wr && addr == 3'h0 &&
		 wdata[7] && !wdata[6]) |=> state_ff == stop_ctrl_pkg::st_stop)
		else $error("edge mode stop not entered");
	AST_DIV_CLEAR: assert property (
		(state_ff != stop_ctrl_pkg::st_stop) ##1 (state_ff == stop_ctrl_pkg::st_stop)
		|-> div_ff == 8'h00)
		else $error("divider not cleared on stop entry");
	AST_OSC_OFF: assert property (
		state_ff == stop_ctrl_pkg::st_stop |-> !hf_osc_en && !lf_osc_en && cpu_stall)
		else $error("oscillator running in stop");
	AST_PC_STEP: assert property (
		$rose(state_ff == stop_ctrl_pkg::st_stop) |->
		pc_ff == $past(stop_insn_addr) + 16'h0002)
		else $error("resume address wrong");
	AST_GUARD: assert property (
		(state_ff == stop_ctrl_pkg::st_stop && guard_ff && !sc1_ff[6] && !s.key &&
		 !s.vd_rel && !s.rst_req) |=> state_ff != stop_ctrl_pkg::st_warm)
		else $error("released inside blanking cycle");
	AST_WARM_EXIT: assert property (
		(state_ff == stop_ctrl_pkg::st_warm && wu_done && !s.rst_req) |=>
		!cpu_stall && periph_clk_en)
		else $error("stall not released after warm-up");
	AST_NO_RESTOP: assert property (
		(state_ff == stop_ctrl_pkg::st_warm && !wu_done) |=>
		state_ff != stop_ctrl_pkg::st_stop)
		else $error("stop re-entered during warm-up");
	AST_RESET: assert property (
		s.rst_req |=> state_ff == stop_ctrl_pkg::st_reset && !sc2_ff[5])
		else $error("system reset did not end stop");
	AST_IDLE_EXIT: assert property (
		(state_ff == stop_ctrl_pkg::st_timebase_only_idle_mode && !tb_fall && !s.rst_req) |=>
		state_ff == stop_ctrl_pkg::st_timebase_only_idle_mode)
		else $error("idle left without timebase falling edge");
endmodule

// ==== rtl/stop_ctrl_pkg.sv ====
// Shared constants and types of the STOP-mode power controller.
// Assumes a single 40 MHz clock and an 8-bit register port.
package stop_ctrl_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned GEAR_MC_NS    = 25;  // One gear clock period
	localparam int unsigned GEAR_MC_CYC   =
		(GEAR_MC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  LF_PER_MC     = 2'h3; // Four low-clock periods, minus one
	localparam logic [3:0]  WU_UNIT_TICKS = 4'hF; // Sixteen source ticks per unit, minus one

	// ==========================================================
	// Register indices on the plain port
	localparam logic [2:0] ADDR_SC1    = 3'h0;
	localparam logic [2:0] ADDR_SC2    = 3'h1;
	localparam logic [2:0] ADDR_WUCC   = 3'h2;
	localparam logic [2:0] ADDR_WUCD   = 3'h3;
	localparam logic [2:0] ADDR_TBTC   = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;

	// ==========================================================
	// Field positions and reset values
	localparam int unsigned SC1_STOP  = 7;
	localparam int unsigned SC1_RELEASE_MODE_SELECT  = 6;
	localparam int unsigned SC1_HOLD  = 4;
	localparam int unsigned SC2_HFEN  = 7;
	localparam int unsigned SC2_LFEN  = 6;
	localparam int unsigned SC2_SLOW  = 5;
	localparam int unsigned SC2_TGH   = 2;
	localparam logic [7:0]  SC1_RST   = 8'h00;
	localparam logic [7:0]  SC2_RST   = 8'h80;
	localparam logic [7:0]  WUCC_RST  = 8'h00;
	localparam logic [7:0]  WUCD_RST  = 8'h10;
	localparam logic [2:0]  TBTC_RST  = 3'h0;
	localparam logic [15:0] PC_STEP   = 16'h0002;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {st_reset, st_run, st_timebase_only_idle_mode, st_stop, st_warm} mode_t;

	typedef struct packed {
		logic wake;     // Dedicated wake pin
		logic key;      // Key-on wakeup request level
		logic vd_rel;   // Voltage detector release
		logic lf_clk;   // Low-frequency clock level
		logic rst_req;  // Pin, power-on or detector reset
	} pins_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for every pin that enters the controller.
// Assumes all inputs are asynchronous to clock.
`timescale 1ns/10ps
module pin_sync (
	input  wire logic                 clock,
	input  wire logic                 arst_n,
	input  wire stop_ctrl_pkg::pins_t pins,
	output      stop_ctrl_pkg::pins_t pins_s
);
	stop_ctrl_pkg::pins_t meta_ff;
	stop_ctrl_pkg::pins_t sync_ff;
	stop_ctrl_pkg::pins_t nxt_meta;
	stop_ctrl_pkg::pins_t nxt_sync;

	// ==========================================================
	// Next values; first stage feeds only the second
	always_comb begin
		nxt_meta = pins;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign pins_s = sync_ff;
endmodule

// ==== rtl/warmup_timer.sv ====
// Warm-up counter: counts units of sixteen source ticks after start.
// Assumes tick is a one-cycle enable from the same clock.
`timescale 1ns/10ps
module warmup_timer (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       start,
	input  wire logic       tick,
	input  wire logic [7:0] units,
	output      logic       busy,
	output      logic       done
);
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	logic        busy_ff;
	logic        nxt_busy;
	logic        done_ff;
	logic        nxt_done;

	// ==========================================================
	// Down count; zero units finishes on the next edge
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (start) begin
			nxt_cnt  = {units, stop_ctrl_pkg::WU_UNIT_TICKS};
			nxt_busy = 1'b1;
			if (units == 8'h00) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end else if (busy_ff && tick) begin
			nxt_cnt = cnt_ff - 12'h001;
			if (cnt_ff == 12'h000) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff  <= 12'h000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
endmodule

// ==== verif/wake_source.sv ====
// Behavioural source that drives the dedicated wake pin of the controller.
// Assumes the bench names the wanted level and a lag in clock cycles.
`timescale 1ns/10ps
module wake_source (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       want,
	input  wire logic [3:0] lag,
	output      logic       wake
);
	logic [3:0] wait_ff;

	// ==========================================================
	// Level follower
	// Lag lets one model act as a prompt or a slow source
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wake    <= 1'b0;
			wait_ff <= 4'h0;
		end else if (want == wake) begin
			wait_ff <= 4'h0;
		end else if (wait_ff >= lag) begin
			wake    <= want;
			wait_ff <= 4'h0;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the STOP-mode power controller.
// Assumes the controller and the wake source model are compiled before it.
`timescale 1ns/10ps
module testbench;
	// ==========================================================
	// Signals
	logic                 clock;
	logic                 arst_n;
	logic                 key;
	logic                 vd_rel;
	logic                 rst_req;
	logic                 wake;
	logic                 wake_want;
	logic [3:0]           wake_lag;
	logic [2:0]           lf_div;
	stop_ctrl_pkg::pins_t pins;
	logic [15:0]          stop_insn_addr;
	logic [2:0]           addr;
	logic [7:0]           wdata;
	logic                 wr;
	logic                 rd;
	logic                 rd_q;
	logic [7:0]           rdata;
	logic                 hf_osc_en;
	logic                 lf_osc_en;
	logic                 cpu_stall;
	logic                 periph_clk_en;
	logic                 tbt_clk_en;
	logic                 port_drive_en;
	logic                 mc_tick;
	logic [15:0]          resume_addr;
	logic [7:0]           tg_div;
	logic [15:0]          pc;
	logic [7:0]           exp_q[$];
	int                   failures = 0;
	int                   n_checks = 0;
	int                   cycles   = 0;
	int                   n;
	localparam logic [7:0] RUN_STATUS = {5'h00, stop_ctrl_pkg::st_run};

	// Slow clock of eight fast cycles; kept running, slow mode is set only in the slow-mode STOP test
	assign pins = {wake, key, vd_rel, lf_div[2], rst_req};

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	stop_mode_power_controller u_stop_mode_power_controller (
		.clock          (clock),
		.arst_n         (arst_n),
		.pins           (pins),
		.stop_insn_addr (stop_insn_addr),
		.addr           (addr),
		.wdata          (wdata),
		.wr             (wr),
		.rd             (rd),
		.rdata          (rdata),
		.hf_osc_en      (hf_osc_en),
		.lf_osc_en      (lf_osc_en),
		.cpu_stall      (cpu_stall),
		.periph_clk_en  (periph_clk_en),
		.tbt_clk_en     (tbt_clk_en),
		.port_drive_en  (port_drive_en),
		.mc_tick        (mc_tick),
		.resume_addr    (resume_addr),
		.tg_div         (tg_div)
	);

	wake_source u_wake_source (
		.clock  (clock),
		.arst_n (arst_n),
		.want   (wake_want),
		.lag    (wake_lag),
		.wake   (wake)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Expected data is queued now and compared by the monitor a cycle later
	task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		exp_q.push_back(e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
	endtask

	task automatic set_wake(input logic v);
		@(posedge clock);
		wake_lag  <= 4'($urandom % 4);
		wake_want <= v;
	endtask

	task automatic enter_stop(input logic [7:0] d);
		pc = 16'($urandom);
		@(posedge clock);
		stop_insn_addr <= pc;
		reg_wr(stop_ctrl_pkg::ADDR_SC1, d);
		@(negedge clock);
	endtask

	// Bounded wait for the core to run again; counts cycles spent stalled
	task automatic wait_run(output int k);
		k = 0;
		while (cpu_stall !== 1'b0 && k < 3000) begin
			@(negedge clock);
			k++;
		end
		if (k >= 3000) begin
			failures++;
		end
	endtask

	// ==========================================================
	// Read-data monitor and slow-clock divider
	always @(posedge clock) begin
		if (!arst_n) begin
			rd_q   <= 1'b0;
			lf_div <= 3'h0;
		end else begin
			rd_q   <= rd;
			lf_div <= lf_div + 3'h1;
		end
	end

	always @(negedge clock) begin
		if (rd_q === 1'b1 && exp_q.size() > 0) begin
			check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
		end
	end

	// Hang guard; the whole run needs under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			print_verdict();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(61));
		{arst_n, key, vd_rel, rst_req, wake_want, wr, rd} = 7'h00;
		{wake_lag, addr, wdata, stop_insn_addr} = 31'h0;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		wait_run(n);
		// Reset warm-up: (count + 1) units of sixteen gear ticks, plus entry and exit
		check(16'(n), ({8'h00, stop_ctrl_pkg::WUCD_RST} + 16'h0001) * 16'h0010 + 16'h0002);
		check({15'h0000, mc_tick}, 16'h0001);
		reg_rd(stop_ctrl_pkg::ADDR_SC2, stop_ctrl_pkg::SC2_RST);
		reg_rd(stop_ctrl_pkg::ADDR_WUCD, stop_ctrl_pkg::WUCD_RST);
		reg_rd(3'h6, 8'h00);
		reg_rd(stop_ctrl_pkg::ADDR_STATUS, RUN_STATUS);
		reg_wr(stop_ctrl_pkg::ADDR_WUCD, 8'h00);
		// Edge mode entered with wake already high, then a fresh rising edge
		set_wake(1'b1);
		repeat (10) @(posedge clock);
		enter_stop(8'h80);
		check({12'h000, cpu_stall, hf_osc_en, lf_osc_en, port_drive_en}, 16'h0008);
		check(resume_addr, pc + stop_ctrl_pkg::PC_STEP);
		check({8'h00, tg_div}, 16'h0000);
		repeat (10) @(negedge clock);
		check({14'h0000, cpu_stall, hf_osc_en}, 16'h0002);
		set_wake(1'b0);
		repeat (12) @(posedge clock);
		set_wake(1'b1);
		@(negedge clock);
		wait_run(n);
		// Zero units: two sync stages, pin lag, one warm cycle
		check({15'h0000, n >= 5 && n <= 8}, 16'h0001);
		check(resume_addr, pc + stop_ctrl_pkg::PC_STEP);
		reg_rd(stop_ctrl_pkg::ADDR_SC1, 8'h00);
		// Level mode refused while wake is high
		reg_wr(stop_ctrl_pkg::ADDR_SC1, 8'hC0);
		@(negedge clock);
		check({15'h0000, cpu_stall}, 16'h0000);
		reg_rd(stop_ctrl_pkg::ADDR_SC1, 8'h40);
		// Level mode with held port drive; wake falls again during warm-up
		reg_wr(stop_ctrl_pkg::ADDR_WUCD, 8'h01);
		set_wake(1'b0);
		repeat (12) @(posedge clock);
		check({15'h0000, wake}, 16'h0000);
		enter_stop(8'hD0);
		check({14'h0000, cpu_stall, port_drive_en}, 16'h0003);
		set_wake(1'b1);
		repeat (14) @(posedge clock);
		set_wake(1'b0);
		@(negedge clock);
		wait_run(n);
		check({15'h0000, n >= 22 && n <= 25}, 16'h0001);
		check({15'h0000, hf_osc_en}, 16'h0001);
		reg_wr(stop_ctrl_pkg::ADDR_WUCD, 8'h00);
		// Key wakeup and voltage detector release
		for (int i = 0; i < 2; i++) begin
			enter_stop(8'h80);
			repeat (6) @(posedge clock);
			key    <= (i == 0);
			vd_rel <= (i == 1);
			@(negedge clock);
			wait_run(n);
			check({15'h0000, n <= 30}, 16'h0001);
			@(posedge clock);
			key    <= 1'b0;
			vd_rel <= 1'b0;
		end
		// Slow-mode STOP: warm-up must count low clock edges, not gear cycles
		reg_wr(stop_ctrl_pkg::ADDR_WUCD, 8'h01);
		reg_wr(stop_ctrl_pkg::ADDR_SC2, 8'hE0);
		enter_stop(8'h80);
		repeat (40) @(posedge clock);
		set_wake(1'b1);
		@(negedge clock);
		wait_run(n);
		check({15'h0000, n >= 240 && n <= 280}, 16'h0001);
		reg_rd(stop_ctrl_pkg::ADDR_STATUS, RUN_STATUS | 8'h08);
		// System reset during STOP
		enter_stop(8'h90);
		@(posedge clock);
		rst_req <= 1'b1;
		repeat (4) @(posedge clock);
		rst_req <= 1'b0;
		@(negedge clock);
		check({14'h0000, cpu_stall, hf_osc_en}, 16'h0003);
		wait_run(n);
		reg_rd(stop_ctrl_pkg::ADDR_SC1, stop_ctrl_pkg::SC1_RST);
		reg_rd(stop_ctrl_pkg::ADDR_STATUS, RUN_STATUS);
		// Timebase-only idle and its return
		reg_wr(stop_ctrl_pkg::ADDR_SC2, 8'h84);
		@(negedge clock);
		check({13'h0000, cpu_stall, periph_clk_en, tbt_clk_en}, 16'h0005);
		wait_run(n);
		check({15'h0000, n <= 4}, 16'h0001);
		reg_rd(stop_ctrl_pkg::ADDR_SC2, stop_ctrl_pkg::SC2_RST);
		repeat (4) @(posedge clock);
		print_verdict();
	end
endmodule
